// >>> edr_phase_symbol_mapper.sv
// Baseband bit stream to differential phase symbol mapper
`timescale 1ns/1ps
module edr_phase_symbol_mapper
    import sym_map_pkg::*;
#(
    parameter bit THREE_BIT_EN = 1'b1
)(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Packet start from baseband
    input  wire logic                   pkt_start,
    input  wire sym_map_pkg::pkt_req_s  pkt_req,
    output logic                        pkt_busy,
    // Bit stream from baseband
    input  wire logic [2:0]             bits_data,
    input  wire logic                   bits_valid,
    output logic                        bits_ready,
    // Symbols to modulator
    output sym_map_pkg::symbol_s        sym_out,
    output logic                        sym_valid,
    // Status
    output logic                        underrun
);

    //--------------------------------------------------------------
    // Packet control
    //--------------------------------------------------------------
    state_e                     state_q, state_d;
    scheme_e                    scheme_q;
    logic [SLOT_CNT_W-1:0]      slots_left_q;
    logic [9:0]                 sym_in_slot_q;
    logic [6:0]                 tick_q;
    logic [PHASE_W-1:0]         phase_q;
    symbol_s                    sym_q;
    logic                       sym_valid_q;
    logic                       underrun_q;
    logic                       first_q;

    wire slots_ok  = (pkt_req.slots == SLOT_CNT_W'(SLOTS_1)) ||
                     (pkt_req.slots == SLOT_CNT_W'(SLOTS_3)) ||
                     (pkt_req.slots == SLOT_CNT_W'(SLOTS_5));
    // Optional three-bit scheme falls back to two-bit when absent
    wire scheme_e  req_scheme = pkt_req.is_control ? SCHEME_BASIC :
                     (pkt_req.scheme == SCHEME_THREE && !THREE_BIT_EN) ? SCHEME_TWO :
                     (pkt_req.scheme == SCHEME_THREE) ? SCHEME_THREE :
                     (pkt_req.scheme == SCHEME_TWO) ? SCHEME_TWO : SCHEME_BASIC;
    wire accept    = (state_q == ST_IDLE) && pkt_start && slots_ok;
    wire sym_tick  = (state_q == ST_SEND) && (tick_q == 7'(SYM_CYCLES - 1));
    wire slot_end  = sym_in_slot_q == 10'(SYM_PER_SLOT - 1);
    wire pkt_end   = sym_tick && slot_end && (slots_left_q == SLOT_CNT_W'(1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (accept) state_d = ST_SEND;
            ST_SEND: if (pkt_end) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) state_q <= ST_IDLE;
        else        state_q <= state_d;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scheme_q <= SCHEME_BASIC;
            slots_left_q <= '0;
        end else if (accept) begin
            scheme_q <= req_scheme;
            slots_left_q <= pkt_req.slots;
        end else if (sym_tick && slot_end) begin
            slots_left_q <= slots_left_q - SLOT_CNT_W'(1);
        end
    end

    //--------------------------------------------------------------
    // Symbol and slot timing
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= '0;
            sym_in_slot_q <= '0;
        end else if (state_q != ST_SEND) begin
            tick_q <= '0;
            sym_in_slot_q <= '0;
        end else if (sym_tick) begin
            tick_q <= '0;
            sym_in_slot_q <= slot_end ? 10'h000 : sym_in_slot_q + 10'h001;
        end else begin
            tick_q <= tick_q + 7'h01;
        end
    end

    //--------------------------------------------------------------
    // Bit grouping and phase mapping
    //--------------------------------------------------------------
    logic [2:0] step;
    // Missing bits send a zero group; zero is the least disturbing step
    wire [2:0] grp = bits_valid ? bits_data : 3'h0;

    phase_step_lut u_lut (
        .scheme (scheme_q),
        .bits   (grp),
        .step   (step)
    );

    assign bits_ready = sym_tick;
    assign pkt_busy   = state_q != ST_IDLE;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PHASE_RESET;
            sym_q <= '0;
            sym_valid_q <= 1'b0;
            underrun_q <= 1'b0;
            first_q <= 1'b0;
        end else begin
            sym_valid_q <= sym_tick;
            if (accept) begin
                phase_q <= PHASE_RESET;
                first_q <= 1'b1;
                underrun_q <= 1'b0;
            end else if (sym_tick) begin
                phase_q <= phase_q + step;
                first_q <= 1'b0;
                sym_q.basic_bit <= (scheme_q == SCHEME_BASIC) ? grp[0] : 1'b0;
                sym_q.step <= step;
                sym_q.phase <= phase_q + step;
                sym_q.first <= first_q;
                sym_q.last <= pkt_end;
                if (!bits_valid) underrun_q <= 1'b1;
            end
        end
    end

    assign sym_out   = sym_q;
    assign sym_valid = sym_valid_q;
    assign underrun  = underrun_q;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    // Own count of cycles between ticks, so the rate check does not lean on tick_q
    logic [9:0]                 sym_gap_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sym_gap_q <= '0;
        end else if (accept || sym_tick) begin
            sym_gap_q <= '0;
        end else begin
            sym_gap_q <= sym_gap_q + 10'h001;
        end
    end

    property p_two_not_pi;
        @(posedge sys_clk) disable iff (!rst_n)
        sym_tick && scheme_q == SCHEME_TWO |-> step[0];
    endproperty
    a_two_not_pi: assert property (p_two_not_pi)
        else $error("two-bit step is even");

    property p_two_map;
        @(posedge sys_clk) disable iff (!rst_n)
        sym_tick && scheme_q == SCHEME_TWO && grp[1:0] == 2'h2 |=> sym_q.step == 3'h5;
    endproperty
    a_two_map: assert property (p_two_map)
        else $error("pair 10 not -3pi/4");

    property p_three_map;
        @(posedge sys_clk) disable iff (!rst_n)
        sym_tick && scheme_q == SCHEME_THREE && grp == 3'h6 |=> sym_q.step == 3'h4;
    endproperty
    a_three_map: assert property (p_three_map)
        else $error("triple 110 not pi");

    property p_basic_step;
        @(posedge sys_clk) disable iff (!rst_n)
        sym_tick && scheme_q == SCHEME_BASIC |=> sym_q.step == 3'h0;
    endproperty
    a_basic_step: assert property (p_basic_step)
        else $error("basic rate moved phase");

    property p_control_basic;
        @(posedge sys_clk) disable iff (!rst_n)
        accept && pkt_req.is_control |=> scheme_q == SCHEME_BASIC;
    endproperty
    a_control_basic: assert property (p_control_basic)
        else $error("control packet not basic");

    sequence s_tick;
        sym_tick;
    endsequence
    property p_rate;
        @(posedge sys_clk) disable iff (!rst_n)
        s_tick |-> sym_gap_q == 10'(SYM_CYCLES - 1);
    endproperty
    a_rate: assert property (p_rate)
        else $error("symbol period not 1 us");

    property p_rate_gap;
        @(posedge sys_clk) disable iff (!rst_n)
        (state_q == ST_SEND) |-> sym_gap_q < 10'(SYM_CYCLES);
    endproperty
    a_rate_gap: assert property (p_rate_gap)
        else $error("symbol tick overdue");

    property p_phase_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        accept |=> phase_q == PHASE_RESET;
    endproperty
    a_phase_clear: assert property (p_phase_clear)
        else $error("phase not cleared at start");

    property p_phase_acc;
        @(posedge sys_clk) disable iff (!rst_n)
        sym_tick && !accept |=> phase_q == 3'($past(phase_q) + $past(step));
    endproperty
    a_phase_acc: assert property (p_phase_acc)
        else $error("phase accumulation wrong");

    property p_slots;
        @(posedge sys_clk) disable iff (!rst_n)
        accept |=> slots_left_q == 3'h1 || slots_left_q == 3'h3 || slots_left_q == 3'h5;
    endproperty
    a_slots: assert property (p_slots)
        else $error("illegal slot count");

endmodule

// >>> phase_step_lut.sv
// Bit group to differential phase step lookup
`timescale 1ns/1ps
module phase_step_lut
    import sym_map_pkg::*;
(
    // Selection
    input  wire sym_map_pkg::scheme_e scheme,
    input  wire logic [2:0]           bits,
    // Result, units of pi/4
    output logic [2:0]                step
);

    // Two-bit steps never reach 4 (pi) by construction
    wire [2:0] step_two = (bits[1:0] == 2'h0) ? 3'h1 :
                          (bits[1:0] == 2'h1) ? 3'h3 :
                          (bits[1:0] == 2'h2) ? 3'h5 : 3'h7;

    // Gray-coded triples walk the circle in pi/4 steps
    wire [2:0] step_three = (bits == 3'h0) ? 3'h0 :
                            (bits == 3'h1) ? 3'h1 :
                            (bits == 3'h3) ? 3'h2 :
                            (bits == 3'h2) ? 3'h3 :
                            (bits == 3'h6) ? 3'h4 :
                            (bits == 3'h7) ? 3'h5 :
                            (bits == 3'h5) ? 3'h6 : 3'h7;

    assign step = (scheme == SCHEME_TWO)   ? step_two :
                  (scheme == SCHEME_THREE) ? step_three : 3'h0;

endmodule

// >>> sym_map_pkg.sv
// Package: constants and carrier types for the phase symbol mapper
package sym_map_pkg;

    // Symbol and slot timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SYM_HZ          = 1_000_000;
    localparam int unsigned SYM_CYCLES      = CLK_HZ / SYM_HZ;
    localparam int unsigned SLOT_US         = 625;
    localparam int unsigned SYM_PER_SLOT    = (SYM_HZ / 1_000_000) * SLOT_US;
    localparam int unsigned SLOTS_1         = 1;
    localparam int unsigned SLOTS_3         = 3;
    localparam int unsigned SLOTS_5         = 5;
    localparam int unsigned SLOT_CNT_W      = 3;

    // Phase accumulator, units of pi/4
    localparam int unsigned PHASE_W         = 3;
    localparam logic [2:0]  PHASE_RESET     = 3'h0;

    // Bits per symbol
    localparam logic [1:0]  BITS_BASIC      = 2'h1;
    localparam logic [1:0]  BITS_TWO        = 2'h2;
    localparam logic [1:0]  BITS_THREE      = 2'h3;

    typedef enum logic [1:0] {
        SCHEME_BASIC = 2'h0,
        SCHEME_TWO   = 2'h1,
        SCHEME_THREE = 2'h2
    } scheme_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEND = 2'h1,
        ST_DONE = 2'h3
    } state_e;

    // Packet start request from baseband
    typedef struct packed {
        scheme_e                scheme;
        logic                   is_control;
        logic [SLOT_CNT_W-1:0]  slots;
    } pkt_req_s;

    // Symbol handed to the modulator front end
    typedef struct packed {
        logic                   basic_bit;
        logic [PHASE_W-1:0]     step;
        logic [PHASE_W-1:0]     phase;
        logic                   first;
        logic                   last;
    } symbol_s;

endpackage

// >>> sym_src_model.sv
// Baseband bit source model feeding the phase symbol mapper
`timescale 1ns/1ps
module sym_src_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Bench control
    input  wire logic       restart,
    input  wire logic [9:0] gap_idx,
    // Stream to mapper
    input  wire logic       bits_ready,
    output logic [2:0]      bits_data,
    output logic            bits_valid
);
    logic [9:0] idx_q;

    // Group n carries n mod 8, so every code appears in turn
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 10'h000;
        end else if (restart) begin
            idx_q <= 10'h000;
        end else if (bits_ready) begin
            idx_q <= idx_q + 10'h001;
        end
    end

    // Withheld group shows a wrong value so a stale read is caught
    assign bits_valid = (idx_q != gap_idx);
    assign bits_data  = bits_valid ? idx_q[2:0] : ~idx_q[2:0];
endmodule

// >>> tb_edr_phase_symbol_mapper.sv
// Self-checking testbench for the phase symbol mapper
`timescale 1ns/1ps
module tb_edr_phase_symbol_mapper;
    import sym_map_pkg::*;
    logic       sys_clk   = 1'b0;
    logic       rst_n     = 1'b0;
    logic       pkt_start = 1'b0;
    pkt_req_s   pkt_req   = '0;
    logic [9:0] gap_idx   = 10'h3FF;
    logic       pkt_busy;
    logic [2:0] bits_data;
    logic       bits_valid;
    logic       bits_ready;
    symbol_s    sym_out;
    logic       sym_valid;
    logic       underrun;
    logic [2:0] phase_q;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles     = 0;

    always #5 sys_clk = ~sys_clk;

    edr_phase_symbol_mapper u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pkt_start(pkt_start),
        .pkt_req(pkt_req), .pkt_busy(pkt_busy), .bits_data(bits_data),
        .bits_valid(bits_valid), .bits_ready(bits_ready), .sym_out(sym_out),
        .sym_valid(sym_valid), .underrun(underrun));

    sym_src_model u_src (.sys_clk(sys_clk), .rst_n(rst_n), .restart(pkt_start & ~pkt_busy),
        .gap_idx(gap_idx), .bits_ready(bits_ready), .bits_data(bits_data),
        .bits_valid(bits_valid));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [2:0] exp_step(input scheme_e s, input logic c, input logic [2:0] g);
        logic [2:0] t8 [8];
        t8 = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4, 3'h5};
        if (c || s == SCHEME_BASIC) return 3'h0;
        if (s == SCHEME_TWO) return {g[1:0], 1'b1};
        return t8[g];
    endfunction

    task automatic hw_reset();
        @(negedge sys_clk);
        rst_n   = 1'b0;
        gap_idx = 10'h3FF;
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask

    task automatic start_pkt(input scheme_e s, input logic c, input logic [2:0] n);
        @(negedge sys_clk);
        pkt_req   = '{scheme: s, is_control: c, slots: n};
        pkt_start = 1'b1;
        @(negedge sys_clk);
        pkt_start = 1'b0;
        phase_q   = 3'h0;
    endtask

    // Waits each symbol, checks spacing, mapping, phase and framing flags
    task automatic run_syms(input scheme_e s, input logic c, input int n, input int total);
        int         k;
        logic [2:0] g;
        logic [2:0] st;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(negedge sys_clk);
                k++;
            end while (sym_valid !== 1'b1 && k < 200);
            g       = (i == gap_idx) ? 3'h0 : 3'(i);
            st      = exp_step(s, c, g);
            phase_q = phase_q + st;
            check("spacing", 10'(k), 10'(SYM_CYCLES));
            check("step", sym_out.step, st);
            check("phase", sym_out.phase, phase_q);
            check("first", sym_out.first, i == 0);
            check("last", sym_out.last, i == total - 1);
            if (c || s == SCHEME_BASIC) check("bit", sym_out.basic_bit, g[0]);
            if (s == SCHEME_TWO && !c) check("no_pi", sym_out.step == 3'h4, 1'b0);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_refuse();
        logic [2:0] bad [4];
        bad = '{3'h0, 3'h2, 3'h4, 3'h7};
        foreach (bad[j]) begin
            start_pkt(SCHEME_TWO, 1'b0, bad[j]);
            check("busy_bad_slots", pkt_busy, 1'b0);
        end
    endtask

    task automatic t_two();
        start_pkt(SCHEME_TWO, 1'b0, 3'h3);
        check("busy", pkt_busy, 1'b1);
        gap_idx = 10'd8;
        run_syms(SCHEME_TWO, 1'b0, 9, 1875);
        check("underrun", underrun, 1'b1);
    endtask

    task automatic t_three();
        start_pkt(SCHEME_THREE, 1'b0, 3'h5);
        run_syms(SCHEME_THREE, 1'b0, 8, 3125);
        check("underrun_clear", underrun, 1'b0);
    endtask

    task automatic t_basic();
        start_pkt(SCHEME_BASIC, 1'b0, 3'h1);
        run_syms(SCHEME_BASIC, 1'b0, 4, 625);
    endtask

    // Control traffic over a whole slot, then a new packet started once busy has dropped
    task automatic t_ctrl_full();
        start_pkt(SCHEME_THREE, 1'b1, 3'h1);
        run_syms(SCHEME_THREE, 1'b1, 625, 625);
        repeat (3) @(negedge sys_clk);
        check("busy_end", pkt_busy, 1'b0);
        start_pkt(SCHEME_TWO, 1'b0, 3'h1);
        check("busy_next", pkt_busy, 1'b1);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        hw_reset();
        t_refuse();
        t_two();
        hw_reset();
        t_three();
        hw_reset();
        t_basic();
        hw_reset();
        t_ctrl_full();
        report_and_stop();
    end
endmodule
